/* File: verilog/mmg_defs.vh */
/*
 constants of the mode and memory guard: mode codes, register offsets,
 field positions, security row layout and default partition map.
 assumes inclusion by bare name from the guard modules.
*/
`ifndef MMG_DEFS_VH
`define MMG_DEFS_VH

// ************************************************************
// cpu modes (super sub-states share the low codes)
// ************************************************************
`define MMG_MODE_BOOT 3'h0
`define MMG_MODE_TEST 3'h1
`define MMG_MODE_CLP 3'h2
`define MMG_MODE_SYS 3'h3
`define MMG_MODE_USER 3'h4
`define MMG_SUP_BOOT 2'h0
`define MMG_SUP_TEST 2'h1
`define MMG_SUP_CLP 2'h2

// ************************************************************
// register offsets and fields
// ************************************************************
`define MMG_OFF_MODE 12'h000
`define MMG_OFF_CLP_RD 12'h004
`define MMG_OFF_CLP_WR 12'h008
`define MMG_OFF_LOCK 12'h00c
`define MMG_OFF_SEG_IDX 12'h010
`define MMG_OFF_SEG_START 12'h014
`define MMG_OFF_SEG_END 12'h018
`define MMG_OFF_SEG_OFFS 12'h01c
`define MMG_OFF_SEG_ATTR 12'h020
`define MMG_OFF_CAUSE 12'h024
`define MMG_OFF_BANKED 12'h028
`define MMG_ROW_PAGE 4'h1
`define MMG_PSW_SM 0
`define MMG_PSW_SSM 1
`define MMG_MODE_LSB 2
`define MMG_MODE_MSB 4
`define MMG_ATTR_R 0
`define MMG_ATTR_W 1
`define MMG_ATTR_X 2
`define MMG_ATTR_END 3
`define MMG_ATTR_GRP_LSB 16
`define MMG_ATTR_GRP_MSB 31
`define MMG_CAUSE_VIOL 0
`define MMG_CAUSE_RANGE 1
`define MMG_DENY_RDATA 32'h00000000

// ************************************************************
// security row word indices
// ************************************************************
`define MMG_ROW_WP_FIRST 5'h08
`define MMG_ROW_WO_FIRST 5'h0c
`define MMG_ROW_FAC_FIRST 5'h14
`define MMG_ROW_WORDS 5'h18

// ************************************************************
// default partition map, fixed at production
// ************************************************************
`define MMG_RAM_BASE 24'h000000
`define MMG_RAM_SPLIT 24'h000800
`define MMG_RAM_END 24'h001000
`define MMG_EE_BASE 24'h100000
`define MMG_EE_SPLIT 24'h108000
`define MMG_EE_END 24'h110000
`define MMG_ROM_BASE 24'h200000
`define MMG_ROM_SPLIT 24'h210000
`define MMG_ROM_END 24'h220000

`endif

/* File: verilog/mmg_seg_match.v */
/*
 one segment descriptor compare: window hit and relocated address.
 assumes start/end/offset come from the descriptor table of the guard.
*/
`timescale 1ns/1ps
`default_nettype none

module mmg_seg_match #(
	parameter AW = 24
) (
	input wire [AW-1:0] vaddr,
	input wire [AW-1:0] seg_start,
	input wire [AW-1:0] seg_end,
	input wire [AW-1:0] seg_offs,
	output wire hit,
	output wire [AW-1:0] paddr
);

	// ************************************************************
	// window and relocation
	// ************************************************************
	// end address is inclusive
	assign hit = (vaddr >= seg_start) && (vaddr <= seg_end);
	// wraps modulo the address space on purpose
	assign paddr = vaddr + seg_offs;

endmodule

`default_nettype wire

/* File: verilog/mmg_mode_mem_guard.v */
/*
 mode sequencing, security row, mmu with segment table and register
 access control, reached over an apb slave.
 assumes cpu event inputs are one-cycle pulses on clk_sys; test and
 fuse pins are asynchronous.
*/
// Summary of operation
// - reset always starts in boot mode, invisible to software.
// - end of boot goes to test if available, else system mode.
// - boot may go to test or contactless; never back to boot.
// - delivery fuse blocks test mode entry permanently.
// - boot mode exists only in start-up after reset.
// - after start-up and test, set super bit means contactless mode.
// - read-only row area of 32 bytes, software writable only in test mode.
// - 16-byte row area that software may lock against writes.
// - 32-byte write-once area, bits only go from 0 to 1.
// - factory data area has no hardware protection.
// - cpu virtual address becomes physical address for memories.
// - test mode reaches both memory parts, others only one.
// - partition bounds fixed at production, not software alterable.
// - segments written in system mode, checked only in user mode.
// - descriptor holds rights, start, end, offset, group rights.
// - offset relocates segment; result still partition checked.
// - up to 64 descriptors; reserved codes end or skip entries.
// - 16 group rights reported; full in boot, test, system.
// - contactless group rights from two regs, locked in that mode.
// - exception on forbidden user access or out-of-range address.
// - refused write leaves register; refused read gives constant.
// - some registers banked for user, system and super modes.
// - two status bits encode super, system or user mode.
// - software writes may only clear the two mode bits.
`timescale 1ns/1ps
`default_nettype none
`include "mmg_defs.vh"

module mmg_mode_mem_guard #(
	parameter AW = 24,
	parameter NSEG = 64,
	parameter IW = 6,
	parameter [23:0] RAM_BASE = `MMG_RAM_BASE,
	parameter [23:0] RAM_SPLIT = `MMG_RAM_SPLIT,
	parameter [23:0] RAM_END = `MMG_RAM_END,
	parameter [23:0] EE_BASE = `MMG_EE_BASE,
	parameter [23:0] EE_SPLIT = `MMG_EE_SPLIT,
	parameter [23:0] EE_END = `MMG_EE_END,
	parameter [23:0] ROM_BASE = `MMG_ROM_BASE,
	parameter [23:0] ROM_SPLIT = `MMG_ROM_SPLIT,
	parameter [23:0] ROM_END = `MMG_ROM_END
) (
	input wire clk_sys,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output wire pready,
	output wire pslverr,
	input wire test_avail_pin,
	input wire delivery_fuse_pin,
	input wire boot_done,
	input wire test_exit,
	input wire clp_enter,
	input wire sys_enter,
	input wire user_enter,
	input wire psw_restore,
	input wire [1:0] psw_restore_val,
	input wire cpu_req,
	input wire cpu_we,
	input wire cpu_fetch,
	input wire [AW-1:0] cpu_vaddr,
	output reg mem_req_q,
	output reg mem_we_q,
	output reg [AW-1:0] mem_paddr_q,
	output reg exc_req_q,
	output reg [2:0] cpu_mode_q,
	output reg [15:0] grp_rd_q,
	output reg [15:0] grp_wr_q
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg [1:0] test_sync_q;
	reg [1:0] fuse_sync_q;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			test_sync_q <= 2'h0;
			fuse_sync_q <= 2'h0;
		end else begin
			test_sync_q <= {test_sync_q[0], test_avail_pin};
			fuse_sync_q <= {fuse_sync_q[0], delivery_fuse_pin};
		end
	end
	// fuse pin stays high once blown, so the level is enough
	wire test_ok = test_sync_q[1] & ~fuse_sync_q[1];

	// ************************************************************
	// apb decode
	// ************************************************************
	wire setup = psel & ~penable;
	wire acc_wr = psel & penable & pwrite;
	wire [4:0] row_idx = paddr[6:2];
	wire row_hit = (paddr[11:8] == `MMG_ROW_PAGE) && !paddr[7] && (row_idx < `MMG_ROW_WORDS);
	reg known;
	always @* begin
		case (paddr)
		`MMG_OFF_MODE, `MMG_OFF_CLP_RD, `MMG_OFF_CLP_WR, `MMG_OFF_LOCK,
		`MMG_OFF_SEG_IDX, `MMG_OFF_SEG_START, `MMG_OFF_SEG_END,
		`MMG_OFF_SEG_OFFS, `MMG_OFF_SEG_ATTR, `MMG_OFF_CAUSE,
		`MMG_OFF_BANKED: known = 1'b1;
		default: known = row_hit;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~known;
	wire wr_ok = acc_wr & known;

	// ************************************************************
	// mode state
	// ************************************************************
	reg ssm_q;
	reg sm_q;
	reg [1:0] sup_q;
	reg ssm_d;
	reg sm_d;
	reg [1:0] sup_d;
	wire [2:0] mode = ssm_q ? {1'b0, sup_q} : (sm_q ? `MMG_MODE_SYS : `MMG_MODE_USER);
	wire is_test = (mode == `MMG_MODE_TEST);
	wire is_user = (mode == `MMG_MODE_USER);
	wire is_clp = (mode == `MMG_MODE_CLP);

	function [2:0] mmg_mode_of;
		input s;
		input m;
		input [1:0] sup;
		begin
			mmg_mode_of = s ? {1'b0, sup} : (m ? `MMG_MODE_SYS : `MMG_MODE_USER);
		end
	endfunction

	always @* begin
		ssm_d = ssm_q;
		sm_d = sm_q;
		sup_d = sup_q;
		if (wr_ok && paddr == `MMG_OFF_MODE) begin
			ssm_d = ssm_q & pwdata[`MMG_PSW_SSM];
			sm_d = sm_q & pwdata[`MMG_PSW_SM];
		end
		// hardware events win over a same-cycle software clear
		if (psw_restore) begin
			ssm_d = psw_restore_val[1];
			sm_d = psw_restore_val[0];
		end
		if (sys_enter)
			sm_d = 1'b1;
		if (user_enter) begin
			ssm_d = 1'b0;
			sm_d = 1'b0;
		end
		if (clp_enter)
			ssm_d = 1'b1;
		if (test_exit && sup_q == `MMG_SUP_TEST) begin
			ssm_d = 1'b0;
			sm_d = 1'b1;
		end
		case (sup_q)
		`MMG_SUP_BOOT: begin
			if (boot_done && test_ok) begin
				sup_d = `MMG_SUP_TEST;
				ssm_d = 1'b1;
			end else if (boot_done) begin
				sup_d = `MMG_SUP_CLP;
				ssm_d = 1'b0;
				sm_d = 1'b1;
			end else if (clp_enter || !ssm_d) begin
				sup_d = `MMG_SUP_CLP;
			end
		end
		`MMG_SUP_TEST: begin
			// test may only be left, never re-entered or turned into boot
			if (!ssm_d)
				sup_d = `MMG_SUP_CLP;
		end
		default: sup_d = `MMG_SUP_CLP;
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ssm_q <= 1'b1;
			sm_q <= 1'b0;
			sup_q <= `MMG_SUP_BOOT;
			cpu_mode_q <= `MMG_MODE_BOOT;
		end else begin
			ssm_q <= ssm_d;
			sm_q <= sm_d;
			sup_q <= sup_d;
			cpu_mode_q <= mmg_mode_of(ssm_d, sm_d, sup_d);
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************
	reg [15:0] clp_rd_q;
	reg [15:0] clp_wr_q;
	reg lock_q;
	reg [IW-1:0] idx_q;
	reg [1:0] cause_q;
	reg [31:0] bank_q [0:2];
	reg [31:0] row_q [0:23];
	reg [AW-1:0] seg_start_q [0:NSEG-1];
	reg [AW-1:0] seg_end_q [0:NSEG-1];
	reg [AW-1:0] seg_offs_q [0:NSEG-1];
	reg [31:0] seg_attr_q [0:NSEG-1];
	reg [1:0] exc_cause;
	wire [1:0] bsel = is_user ? 2'h0 : (ssm_q ? 2'h2 : 2'h1);
	wire seg_wr_ok = !is_user && !is_clp && (idx_q < NSEG);
	integer k, kr, ks;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clp_rd_q <= 16'h0000;
			clp_wr_q <= 16'h0000;
			lock_q <= 1'b0;
			idx_q <= {IW{1'b0}};
			cause_q <= 2'h0;
			for (k = 0; k < 3; k = k + 1)
				bank_q[k] <= 32'h00000000;
		end else begin
			// a fresh cause wins over a same-cycle clear
			if (wr_ok && paddr == `MMG_OFF_CAUSE)
				cause_q <= (cause_q & ~pwdata[1:0]) | exc_cause;
			else
				cause_q <= cause_q | exc_cause;
			if (wr_ok && !is_clp && paddr == `MMG_OFF_CLP_RD)
				clp_rd_q <= pwdata[15:0];
			if (wr_ok && !is_clp && paddr == `MMG_OFF_CLP_WR)
				clp_wr_q <= pwdata[15:0];
			if (wr_ok && paddr == `MMG_OFF_LOCK && pwdata[0])
				lock_q <= 1'b1;
			if (wr_ok && paddr == `MMG_OFF_SEG_IDX)
				idx_q <= pwdata[IW-1:0];
			if (wr_ok && paddr == `MMG_OFF_BANKED)
				bank_q[bsel] <= pwdata;
		end
	end

	// row contents are non-volatile in silicon; cleared here for simulation
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (kr = 0; kr < `MMG_ROW_WORDS; kr = kr + 1)
				row_q[kr] <= 32'h00000000;
		end else if (acc_wr && row_hit) begin
			if (row_idx < `MMG_ROW_WP_FIRST) begin
				if (is_test)
					row_q[row_idx] <= pwdata;
			end else if (row_idx < `MMG_ROW_WO_FIRST) begin
				if (!lock_q || is_test)
					row_q[row_idx] <= pwdata;
			end else if (row_idx < `MMG_ROW_FAC_FIRST) begin
				row_q[row_idx] <= row_q[row_idx] | pwdata;
			end else begin
				row_q[row_idx] <= pwdata;
			end
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (ks = 0; ks < NSEG; ks = ks + 1) begin
				seg_start_q[ks] <= {AW{1'b0}};
				seg_end_q[ks] <= {AW{1'b0}};
				seg_offs_q[ks] <= {AW{1'b0}};
				seg_attr_q[ks] <= 32'h00000000;
			end
		end else if (wr_ok && seg_wr_ok) begin
			if (paddr == `MMG_OFF_SEG_START)
				seg_start_q[idx_q] <= pwdata[AW-1:0];
			if (paddr == `MMG_OFF_SEG_END)
				seg_end_q[idx_q] <= pwdata[AW-1:0];
			if (paddr == `MMG_OFF_SEG_OFFS)
				seg_offs_q[idx_q] <= pwdata[AW-1:0];
			if (paddr == `MMG_OFF_SEG_ATTR)
				seg_attr_q[idx_q] <= pwdata;
		end
	end

	// ************************************************************
	// apb read path
	// ************************************************************
	reg [31:0] rd_d;
	always @* begin
		rd_d = `MMG_DENY_RDATA;
		case (paddr)
		`MMG_OFF_MODE: begin
			rd_d[`MMG_PSW_SSM] = ssm_q;
			rd_d[`MMG_PSW_SM] = sm_q;
			// boot is hidden from software: it reads as super mode only
			rd_d[`MMG_MODE_MSB:`MMG_MODE_LSB] = (mode == `MMG_MODE_BOOT) ? `MMG_MODE_CLP : mode;
		end
		`MMG_OFF_CLP_RD: rd_d[15:0] = clp_rd_q;
		`MMG_OFF_CLP_WR: rd_d[15:0] = clp_wr_q;
		`MMG_OFF_LOCK: rd_d[0] = lock_q;
		`MMG_OFF_SEG_IDX: rd_d[IW-1:0] = idx_q;
		`MMG_OFF_SEG_START: if (!is_user) rd_d[AW-1:0] = seg_start_q[idx_q];
		`MMG_OFF_SEG_END: if (!is_user) rd_d[AW-1:0] = seg_end_q[idx_q];
		`MMG_OFF_SEG_OFFS: if (!is_user) rd_d[AW-1:0] = seg_offs_q[idx_q];
		`MMG_OFF_SEG_ATTR: if (!is_user) rd_d = seg_attr_q[idx_q];
		`MMG_OFF_CAUSE: rd_d[1:0] = cause_q;
		`MMG_OFF_BANKED: rd_d = bank_q[bsel];
		default: if (row_hit) rd_d = row_q[row_idx];
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			prdata_q <= 32'h00000000;
		else if (setup)
			prdata_q <= rd_d;
	end

	// ************************************************************
	// segment search
	// ************************************************************
	wire [NSEG-1:0] hit_raw;
	wire [NSEG*AW-1:0] tr_flat;
	genvar g;
	generate
		for (g = 0; g < NSEG; g = g + 1) begin : g_seg
			mmg_seg_match #(.AW(AW)) u_match (
				.vaddr(cpu_vaddr),
				.seg_start(seg_start_q[g]),
				.seg_end(seg_end_q[g]),
				.seg_offs(seg_offs_q[g]),
				.hit(hit_raw[g]),
				.paddr(tr_flat[g*AW +: AW])
			);
		end
	endgenerate

	reg live;
	reg found;
	reg [AW-1:0] sel_pa;
	reg [31:0] sel_attr;
	integer i;
	always @* begin
		live = 1'b1;
		found = 1'b0;
		sel_pa = {AW{1'b0}};
		sel_attr = 32'h00000000;
		for (i = 0; i < NSEG; i = i + 1) begin
			// end marker with no rights closes the table; with rights it is a skip
			if (seg_attr_q[i][`MMG_ATTR_END] && seg_attr_q[i][`MMG_ATTR_X:`MMG_ATTR_R] == 3'h0)
				live = 1'b0;
			if (live && !seg_attr_q[i][`MMG_ATTR_END] && hit_raw[i] && !found) begin
				found = 1'b1;
				sel_pa = tr_flat[i*AW +: AW];
				sel_attr = seg_attr_q[i];
			end
		end
	end

	// ************************************************************
	// access check
	// ************************************************************
	wire [AW-1:0] pa = is_user ? sel_pa : cpu_vaddr;
	wire in_ram = pa >= RAM_BASE && pa < RAM_END;
	wire in_ee = pa >= EE_BASE && pa < EE_END;
	wire in_rom = pa >= ROM_BASE && pa < ROM_END;
	wire in_low = (in_ram && pa < RAM_SPLIT) || (in_ee && pa < EE_SPLIT) || (in_rom && pa < ROM_SPLIT);
	wire perm_ok = cpu_fetch ? sel_attr[`MMG_ATTR_X] : (cpu_we ? sel_attr[`MMG_ATTR_W] : sel_attr[`MMG_ATTR_R]);
	wire range_err = !(in_ram || in_ee || in_rom);
	wire part_err = !range_err && !in_low && !is_test;
	wire seg_err = is_user && !(found && perm_ok);
	always @* begin
		exc_cause = 2'h0;
		exc_cause[`MMG_CAUSE_VIOL] = cpu_req & (part_err | seg_err);
		exc_cause[`MMG_CAUSE_RANGE] = cpu_req & range_err;
	end
	wire exc = |exc_cause;

	// ************************************************************
	// memory side and group rights
	// ************************************************************
	reg [15:0] cur_grp_q;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_paddr_q <= {AW{1'b0}};
			exc_req_q <= 1'b0;
			cur_grp_q <= 16'h0000;
			grp_rd_q <= 16'hffff;
			grp_wr_q <= 16'hffff;
		end else begin
			mem_req_q <= cpu_req & ~exc;
			mem_we_q <= cpu_we;
			mem_paddr_q <= pa;
			exc_req_q <= exc;
			if (cpu_req && cpu_fetch && is_user && found)
				cur_grp_q <= sel_attr[`MMG_ATTR_GRP_MSB:`MMG_ATTR_GRP_LSB];
			if (is_user) begin
				grp_rd_q <= cur_grp_q;
				grp_wr_q <= cur_grp_q;
			end else if (is_clp) begin
				grp_rd_q <= clp_rd_q;
				grp_wr_q <= clp_wr_q;
			end else begin
				grp_rd_q <= 16'hffff;
				grp_wr_q <= 16'hffff;
			end
		end
	end

endmodule

`default_nettype wire

/* File: dv/mmg_guard_assertions.sv */
/*
 checker of the mode and memory guard, bound into its top module.
 assumes one clock and the default partition map of the header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmg_defs.vh"

module mmg_guard_chk #(
	parameter AW = 24
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic test_avail_pin,
	input wire logic delivery_fuse_pin,
	input wire logic boot_done,
	input wire logic clp_enter,
	input wire logic sys_enter,
	input wire logic user_enter,
	input wire logic psw_restore,
	input wire logic cpu_req,
	input wire logic [AW-1:0] cpu_vaddr,
	input wire logic mem_req_q,
	input wire logic [AW-1:0] mem_paddr_q,
	input wire logic exc_req_q,
	input wire logic [2:0] cpu_mode_q,
	input wire logic [15:0] grp_rd_q,
	input wire logic [15:0] grp_wr_q
);
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// other mode events and apb writes are kept out, though the event under test overrides them
	wire quiet = !(psel | sys_enter | user_enter | psw_restore);

	chk_no_reboot: assert property (
		$past(cpu_mode_q) != `MMG_MODE_BOOT |-> cpu_mode_q != `MMG_MODE_BOOT)
		else $error("boot mode re-entered");
	chk_one_answer: assert property (
		cpu_req |=> mem_req_q != exc_req_q)
		else $error("access not answered once");
	chk_no_stray: assert property (
		!cpu_req |=> !mem_req_q && !exc_req_q)
		else $error("answer without access");
	chk_range_exc: assert property (
		cpu_req && cpu_mode_q != `MMG_MODE_USER && cpu_vaddr >= `MMG_ROM_END |=> exc_req_q)
		else $error("out of range access passed");
	chk_ident_map: assert property (
		cpu_req && cpu_mode_q != `MMG_MODE_USER |=> !mem_req_q || mem_paddr_q == $past(cpu_vaddr))
		else $error("wrong physical address");
	chk_upper_part: assert property (
		cpu_req && cpu_mode_q == `MMG_MODE_SYS && cpu_vaddr >= `MMG_RAM_SPLIT
		&& cpu_vaddr < `MMG_RAM_END |=> exc_req_q)
		else $error("upper partition reached");
	chk_full_grp: assert property (
		$past(cpu_mode_q) inside {`MMG_MODE_BOOT, `MMG_MODE_TEST, `MMG_MODE_SYS}
		|-> grp_rd_q == 16'hffff && grp_wr_q == 16'hffff)
		else $error("group rights not full");
	chk_clp_grp: assert property (
		$past(cpu_mode_q) == `MMG_MODE_CLP && $past(cpu_mode_q, 2) == `MMG_MODE_CLP
		|-> $stable(grp_rd_q) && $stable(grp_wr_q))
		else $error("group rights moved in contactless mode");
	chk_fuse_block: assert property (
		delivery_fuse_pin [*3] ##0 (boot_done && cpu_mode_q == `MMG_MODE_BOOT)
		|=> cpu_mode_q != `MMG_MODE_TEST)
		else $error("test mode after fuse");
	chk_boot_sys: assert property (
		!test_avail_pin [*3] ##0 (boot_done && cpu_mode_q == `MMG_MODE_BOOT && quiet
		&& !clp_enter) |=> cpu_mode_q == `MMG_MODE_SYS)
		else $error("boot did not reach system mode");
	chk_clp_enter: assert property (
		clp_enter && quiet && !boot_done && cpu_mode_q inside {`MMG_MODE_BOOT, `MMG_MODE_SYS}
		|=> cpu_mode_q == `MMG_MODE_CLP)
		else $error("super bit not contactless");

	cov_test: cover property (cpu_mode_q == `MMG_MODE_TEST);
	cov_clp: cover property (cpu_mode_q == `MMG_MODE_CLP);
	cov_user_ok: cover property (cpu_req && cpu_mode_q == `MMG_MODE_USER ##1 mem_req_q);
endmodule

bind mmg_mode_mem_guard mmg_guard_chk #(.AW(AW)) u_chk (.clk_sys, .reset_n, .psel,
	.test_avail_pin, .delivery_fuse_pin, .boot_done, .clp_enter, .sys_enter,
	.user_enter, .psw_restore, .cpu_req, .cpu_vaddr, .mem_req_q, .mem_paddr_q,
	.exc_req_q, .cpu_mode_q, .grp_rd_q, .grp_wr_q);
`default_nettype wire

/* File: dv/mmg_cpu_model.sv */
/*
 cpu core model: issues one virtual access and reports its outcome.
 assumes the guard answers one cycle after the request.
*/
`timescale 1ns/1ps
`default_nettype none

module mmg_cpu_model (
	input wire logic clk_sys,
	input wire logic mem_req_q,
	input wire logic exc_req_q,
	input wire logic [23:0] mem_paddr_q,
	output logic cpu_req,
	output logic cpu_we,
	output logic cpu_fetch,
	output logic [23:0] cpu_vaddr
);
	initial begin
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		cpu_fetch = 1'b0;
		cpu_vaddr = 24'h0;
	end
	// ************************************************************
	// one access; idle lines show the inverse, never a stale copy
	// ************************************************************
	task automatic access(input logic [23:0] va, input logic we, input logic fe,
		output logic [31:0] res);
		@(posedge clk_sys);
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_fetch <= fe;
		cpu_vaddr <= va;
		@(posedge clk_sys);
		cpu_req <= 1'b0;
		cpu_we <= ~we;
		cpu_fetch <= ~fe;
		cpu_vaddr <= ~va;
		#1;
		res = {exc_req_q ? 8'hff : 8'h00, mem_req_q ? mem_paddr_q : 24'hffffff};
	endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
 testbench of the mode and memory guard: apb master, cpu model, events.
 assumes zero-wait apb and one-cycle cpu answers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmg_defs.vh"

module tb;
	typedef struct packed {logic [1:0] k; logic [23:0] a; logic [31:0] d; logic [31:0] e;} mmg_row_t;
	logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata_q, r;
	logic pready, pslverr, err, ta = 1'b0, fu = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [1:0] rv = 2'h0;
	logic cpu_req, cpu_we, cpu_fetch, mem_req_q, mem_we_q, exc_req_q;
	logic [23:0] cpu_vaddr, mem_paddr_q;
	logic [2:0] cpu_mode_q;
	logic [15:0] grp_rd_q, grp_wr_q;
	int bad_count = 0, n_checks = 0;
	logic [31:0] segs [4][4] = '{'{32'h100, 32'h1ff, 32'h100000, 32'h00330005},
		'{32'h200, 32'h2ff, 32'h108000, 32'h5}, '{32'h0, 32'h0, 32'h0, 32'h8},
		'{32'h300, 32'h3ff, 32'h0, 32'h1}};
	mmg_row_t rows [16] = '{
		'{2'h0, 24'h100, 32'hffffffff, 32'h0},
		'{2'h0, 24'h120, 32'h12345678, 32'h12345678},
		'{2'h0, 24'h130, 32'h0f, 32'h0f},
		'{2'h0, 24'h130, 32'hf0, 32'hff},
		'{2'h0, 24'h130, 32'h0, 32'hff},
		'{2'h0, 24'h150, 32'ha5a5, 32'ha5a5},
		'{2'h0, 24'h004, 32'h00a5, 32'h00a5},
		'{2'h0, 24'h008, 32'h005a, 32'h005a},
		'{2'h1, 24'h000100, 32'h0, 32'h000100},
		'{2'h1, 24'h000800, 32'h0, 32'hffffffff},
		'{2'h2, 24'h107fff, 32'h0, 32'h107fff},
		'{2'h1, 24'h108000, 32'h0, 32'hffffffff},
		'{2'h3, 24'h20ffff, 32'h0, 32'h20ffff},
		'{2'h3, 24'h210000, 32'h0, 32'hffffffff},
		'{2'h1, 24'h001000, 32'h0, 32'hffffffff},
		'{2'h2, 24'h300000, 32'h0, 32'hffffffff}};

	always #2 clk_sys = ~clk_sys;

	mmg_mode_mem_guard dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready(pready), .pslverr(pslverr), .test_avail_pin(ta),
		.delivery_fuse_pin(fu), .boot_done(ev[0]), .test_exit(ev[1]), .clp_enter(ev[2]),
		.sys_enter(ev[3]), .user_enter(ev[4]), .psw_restore(ev[5]), .psw_restore_val(rv),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_fetch(cpu_fetch), .cpu_vaddr(cpu_vaddr),
		.mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_paddr_q(mem_paddr_q),
		.exc_req_q(exc_req_q), .cpu_mode_q(cpu_mode_q), .grp_rd_q(grp_rd_q),
		.grp_wr_q(grp_wr_q));
	mmg_cpu_model cpu (.clk_sys(clk_sys), .mem_req_q(mem_req_q), .exc_req_q(exc_req_q),
		.mem_paddr_q(mem_paddr_q), .cpu_req(cpu_req), .cpu_we(cpu_we),
		.cpu_fetch(cpu_fetch), .cpu_vaddr(cpu_vaddr));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out;
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic cm(input logic [2:0] e);
		ck({29'h0, cpu_mode_q}, {29'h0, e});
	endtask
	task automatic rst(input logic a, input logic f);
		reset_n <= 1'b0;
		ta <= a;
		fu <= f;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// event pulse, then one more edge so the group rights settle too
	task automatic pulse(input int k);
		@(posedge clk_sys);
		ev[k] <= 1'b1;
		@(posedge clk_sys);
		ev <= 6'h00;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata_q;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		ck(r, e);
	endtask
	task automatic ac(input logic [23:0] va, input logic [1:0] k, input logic [31:0] e);
		cpu.access(va, k == 2'h2, k == 2'h3, r);
		ck(r, e);
		ck({31'h0, mem_we_q}, {31'h0, k == 2'h2});
	endtask

	initial begin
		#100000;
		bad_count++;
		close_out;
	end

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		rst(1'b0, 1'b0);
		cm(`MMG_MODE_BOOT);
		ck({grp_rd_q, grp_wr_q}, 32'hffffffff);
		rc(`MMG_OFF_MODE, 32'h0a);
		pulse(0);
		cm(`MMG_MODE_SYS);
		rc(`MMG_OFF_MODE, 32'h0d);
		foreach (rows[i]) begin
			if (rows[i].k == 2'h0) begin
				apb(1'b1, rows[i].a[11:0], rows[i].d);
				rc(rows[i].a[11:0], rows[i].e);
			end else
				ac(rows[i].a, rows[i].k, rows[i].e);
		end
		rc(`MMG_OFF_CAUSE, 32'h3);
		apb(1'b1, `MMG_OFF_CAUSE, 32'h1);
		rc(`MMG_OFF_CAUSE, 32'h2);
		apb(1'b1, `MMG_OFF_LOCK, 32'h1);
		apb(1'b1, 12'h120, 32'h0);
		rc(12'h120, 32'h12345678);
		apb(1'b0, 12'h160, 32'h0);
		ck({err, r[30:0]}, 32'h80000000);
		apb(1'b1, `MMG_OFF_MODE, 32'h2);
		rc(`MMG_OFF_MODE, 32'h10);
		cm(`MMG_MODE_USER);
		pulse(3);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `MMG_OFF_SEG_IDX, i);
			apb(1'b1, `MMG_OFF_SEG_START, segs[i][0]);
			apb(1'b1, `MMG_OFF_SEG_END, segs[i][1]);
			apb(1'b1, `MMG_OFF_SEG_OFFS, segs[i][2]);
			apb(1'b1, `MMG_OFF_SEG_ATTR, segs[i][3]);
		end
		ac(24'h000200, 2'h2, 32'h000200);
		pulse(4);
		ac(24'h000110, 2'h1, 32'h100110);
		ac(24'h000110, 2'h2, 32'hffffffff);
		ac(24'h000210, 2'h3, 32'hffffffff);
		ac(24'h000110, 2'h3, 32'h100110);
		ac(24'h000310, 2'h1, 32'hffffffff);
		ac(24'h000500, 2'h1, 32'hffffffff);
		ck({grp_rd_q, grp_wr_q}, 32'h00330033);
		rc(`MMG_OFF_SEG_START, 32'h0);
		apb(1'b1, `MMG_OFF_SEG_START, 32'h0);
		apb(1'b1, `MMG_OFF_BANKED, 32'h11);
		pulse(3);
		rc(`MMG_OFF_SEG_START, 32'h300);
		apb(1'b1, `MMG_OFF_BANKED, 32'h22);
		rc(`MMG_OFF_BANKED, 32'h22);
		pulse(4);
		rc(`MMG_OFF_BANKED, 32'h11);
		rv <= 2'h1;
		pulse(5);
		cm(`MMG_MODE_SYS);
		pulse(2);
		cm(`MMG_MODE_CLP);
		ck({grp_wr_q, grp_rd_q}, 32'h005a00a5);
		apb(1'b1, `MMG_OFF_CLP_RD, 32'hffff);
		rc(`MMG_OFF_CLP_RD, 32'h00a5);
		rst(1'b1, 1'b0);
		cm(`MMG_MODE_BOOT);
		pulse(0);
		cm(`MMG_MODE_TEST);
		ac(24'h000800, 2'h1, 32'h000800);
		pulse(1);
		cm(`MMG_MODE_SYS);
		rst(1'b1, 1'b1);
		pulse(0);
		cm(`MMG_MODE_SYS);
		rst(1'b0, 1'b0);
		pulse(2);
		cm(`MMG_MODE_CLP);
		close_out;
	end
endmodule
`default_nettype wire
